// ==== cmd_decode_map.vh ====
// Notes on behaviour
// RQ1 - host sets bit 7 of the command byte to mark it as a command
// RQ2 - transaction field 01 is register addressing, 11 is special function
// RQ3 - host never sends transaction type 00 or 10
// RQ4 - normal command loads five-bit low field as register index
// RQ5 - register index is kept for later reads and writes until replaced
// RQ6 - function 00100 forces interrupt by setting status interrupt bits at 0x13
// RQ7 - 00110 clears light irq, 00111 clears both, 01010 clears unfiltered irq
// RQ8 - host issues no reserved special function codes
// RQ9 - interrupt pin asserts only while an enable bit at 0x00 is set
// RQ10 - forced interrupt stays until a clear function removes it
// RQ11 - clear functions act once and leave no state behind
// RQ12 - enable bit 4 is filtered irq enable, bit 7 unfiltered irq enable; the code lets either bit pass either flag to the pin
// RQ13 - first write byte is command; later bytes go to selected register
`ifndef CMD_DECODE_MAP_VH
`define CMD_DECODE_MAP_VH
`define CMD_BIT 7
`define TRANS_HI 6
`define TRANS_LO 5
`define TRANS_NORMAL 2'b01
`define TRANS_SPECIAL 2'b11
`define SF_FORCE 5'h04
`define SF_CLR_FILT 5'h06
`define SF_CLR_BOTH 5'h07
`define SF_CLR_UNFILT 5'h0a
`define ADDR_ENABLE 5'h00
`define ADDR_STATUS 5'h13
`define EN_FILT_BIT 4
`define EN_UNFILT_BIT 7
`define ST_FILT_BIT 4
`define ST_UNFILT_BIT 5
`define POINTER_RESET 5'h00
`define ENABLE_RESET 8'h00
`define ADDR_HI 4
`define ADDR_LO 0
`define FIRST_RESET 1'b1
`define FLAG_RESET 1'b0
`define PIN_OE_N_RESET 1'b1
`define DATA_RESET 8'h00
`define READ_IDLE 8'h00
`endif

// ==== sf_decode.v ====
`timescale 1ns/1ps
`include "cmd_decode_map.vh"
module sf_decode (
    input wire [7:0] cmd_byte_in,
    output wire is_cmd_out,
    output wire is_normal_out,
    output wire force_out,
    output wire clr_filt_out,
    output wire clr_unfilt_out
);
    wire [1:0] trans = cmd_byte_in[`TRANS_HI:`TRANS_LO];
    wire [4:0] code = cmd_byte_in[`ADDR_HI:`ADDR_LO];
    wire special = cmd_byte_in[`CMD_BIT] && (trans == `TRANS_SPECIAL);
    // RQ2 transaction type decode
    assign is_cmd_out = cmd_byte_in[`CMD_BIT];
    assign is_normal_out = cmd_byte_in[`CMD_BIT] && (trans == `TRANS_NORMAL);
    // RQ6 force code
    assign force_out = special && (code == `SF_FORCE);
    // RQ7 clear codes
    assign clr_filt_out = special && ((code == `SF_CLR_FILT) || (code == `SF_CLR_BOTH));
    assign clr_unfilt_out = special && ((code == `SF_CLR_UNFILT) || (code == `SF_CLR_BOTH));
endmodule // sf_decode

// ==== light_sensor_command_decoder.v ====
`timescale 1ns/1ps
`include "cmd_decode_map.vh"
module light_sensor_command_decoder (
    input wire core_clk_in,
    input wire reset_in,
    input wire wr_start_in,
    input wire wr_byte_valid_in,
    input wire [7:0] wr_byte_in,
    input wire rd_byte_taken_in,
    input wire filt_event_in,
    input wire unfilt_event_in,
    output reg [4:0] reg_pointer_out,
    output reg reg_wr_out,
    output reg [7:0] reg_wr_data_out,
    output reg [7:0] rd_data_out,
    output reg [7:0] enable_out,
    output reg filt_irq_out,
    output reg unfilt_irq_out,
    output wire int_n_out,
    output wire int_oe_n_out
);
    ////////////////////////////////////////////////////////////////
    // held state and its next values
    reg first_q;
    reg first_d;
    reg [4:0] pointer_q;
    reg [4:0] pointer_d;
    reg [7:0] enable_q;
    reg [7:0] enable_d;
    reg filt_q;
    reg filt_d;
    reg unfilt_q;
    reg unfilt_d;
    reg pin_oe_n_q;
    reg pin_oe_n_d;
    reg [7:0] rd_data_d;

    // decoded fields of the incoming byte
    wire is_cmd;
    wire is_normal;
    wire do_force;
    wire do_clr_filt;
    wire do_clr_unfilt;

    // one-cycle strobes, valid only on the byte that carries them
    wire cmd_strobe;
    wire data_strobe;
    wire force_strobe;
    wire clr_filt_strobe;
    wire clr_unfilt_strobe;
    wire pointer_load;
    wire enable_load;

    ////////////////////////////////////////////////////////////////
    // set beats clear: a threshold event in the clear cycle is kept
    function flag_next;
        input cur;
        input set;
        input clr;
        begin
            if (set) begin
                flag_next = 1'b1;
            end else if (clr) begin
                flag_next = 1'b0;
            end else begin
                flag_next = cur;
            end
        end
    endfunction

    // status and enable read back; other addresses live outside
    function [7:0] read_mux;
        input [4:0] ptr;
        input [7:0] en;
        input flag_a;
        input flag_b;
        begin
            read_mux = `READ_IDLE;
            if (ptr == `ADDR_STATUS) begin
                read_mux[`ST_FILT_BIT] = flag_a;
                read_mux[`ST_UNFILT_BIT] = flag_b;
            end else if (ptr == `ADDR_ENABLE) begin
                read_mux = en;
            end
        end
    endfunction

    // pending flag reaches the pin only through an enable
    function irq_visible;
        input [7:0] en;
        input flag_a;
        input flag_b;
        begin
            irq_visible = (flag_a || flag_b) && (en[`EN_FILT_BIT] || en[`EN_UNFILT_BIT]);
        end
    endfunction

    ////////////////////////////////////////////////////////////////
    sf_decode u_dec (
        .cmd_byte_in(wr_byte_in),
        .is_cmd_out(is_cmd),
        .is_normal_out(is_normal),
        .force_out(do_force),
        .clr_filt_out(do_clr_filt),
        .clr_unfilt_out(do_clr_unfilt)
    );

    // RQ13 first byte is command
    assign cmd_strobe = wr_byte_valid_in && first_q && is_cmd;
    assign data_strobe = wr_byte_valid_in && !first_q;
    // RQ2 RQ6 RQ7 decoded actions
    assign force_strobe = cmd_strobe && do_force;
    assign clr_filt_strobe = cmd_strobe && do_clr_filt;
    assign clr_unfilt_strobe = cmd_strobe && do_clr_unfilt;
    assign pointer_load = cmd_strobe && is_normal;
    // RQ12 enable register write
    assign enable_load = data_strobe && (pointer_q == `ADDR_ENABLE);

    ////////////////////////////////////////////////////////////////
    // RQ13 byte framing
    always @* begin
        first_d = first_q;
        if (wr_start_in) begin
            first_d = 1'b1;
        end else if (wr_byte_valid_in) begin
            first_d = 1'b0;
        end
    end

    // RQ4 RQ5 pointer load, hold
    // reads never step the pointer, so rd_byte_taken_in is left unused
    always @* begin
        pointer_d = pointer_q;
        if (pointer_load) begin
            pointer_d = wr_byte_in[`ADDR_HI:`ADDR_LO];
        end
    end

    // RQ12 enable bits
    always @* begin
        enable_d = enable_q;
        if (enable_load) begin
            enable_d = wr_byte_in;
        end
    end

    // RQ6 RQ10 RQ11 flags, one-shot clears
    always @* begin
        filt_d = flag_next(filt_q, force_strobe || filt_event_in, clr_filt_strobe);
        unfilt_d = flag_next(unfilt_q, force_strobe || unfilt_event_in, clr_unfilt_strobe);
    end

    // RQ9 pin gated by enables
    // registered so the pin lines up with the flag and enable views
    always @* begin
        pin_oe_n_d = !irq_visible(enable_q, filt_q, unfilt_q);
    end

    // RQ5 read data from held pointer
    always @* begin
        rd_data_d = read_mux(pointer_q, enable_q, filt_q, unfilt_q);
    end

    ////////////////////////////////////////////////////////////////
    always @(posedge core_clk_in) begin
        if (reset_in) begin
            first_q <= `FIRST_RESET;
            pointer_q <= `POINTER_RESET;
            enable_q <= `ENABLE_RESET;
            filt_q <= `FLAG_RESET;
            unfilt_q <= `FLAG_RESET;
        end else begin
            first_q <= first_d;
            pointer_q <= pointer_d;
            enable_q <= enable_d;
            filt_q <= filt_d;
            unfilt_q <= unfilt_d;
        end
    end

    // views lag the held state by one cycle
    always @(posedge core_clk_in) begin
        if (reset_in) begin
            reg_pointer_out <= `POINTER_RESET;
            enable_out <= `ENABLE_RESET;
            filt_irq_out <= `FLAG_RESET;
            unfilt_irq_out <= `FLAG_RESET;
            pin_oe_n_q <= `PIN_OE_N_RESET;
        end else begin
            reg_pointer_out <= pointer_q;
            enable_out <= enable_q;
            filt_irq_out <= filt_q;
            unfilt_irq_out <= unfilt_q;
            pin_oe_n_q <= pin_oe_n_d;
        end
    end

    // RQ13 data bytes to pointer register
    always @(posedge core_clk_in) begin
        if (reset_in) begin
            reg_wr_out <= 1'b0;
            reg_wr_data_out <= `DATA_RESET;
        end else begin
            reg_wr_out <= data_strobe;
            if (data_strobe) begin
                reg_wr_data_out <= wr_byte_in;
            end
        end
    end

    // RQ5 read data register
    always @(posedge core_clk_in) begin
        if (reset_in) begin
            rd_data_out <= `DATA_RESET;
        end else begin
            rd_data_out <= rd_data_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // RQ9 open drain pin
    // data held low; only the enable moves, so the line never drives high
    assign int_n_out = 1'b0;
    assign int_oe_n_out = pin_oe_n_q;
endmodule // light_sensor_command_decoder

// ==== light_sensor_command_decoder_checker.sv ====
`timescale 1ns/1ps
module light_sensor_command_decoder_checker (
    input wire core_clk_in, input wire reset_in, input wire wr_start_in, input wire wr_byte_valid_in,
    input wire [7:0] wr_byte_in, input wire rd_byte_taken_in, input wire filt_event_in,
    input wire unfilt_event_in, input wire [4:0] reg_pointer_out, input wire reg_wr_out,
    input wire [7:0] reg_wr_data_out, input wire [7:0] rd_data_out, input wire [7:0] enable_out,
    input wire filt_irq_out, input wire unfilt_irq_out, input wire int_n_out, input wire int_oe_n_out
);
default clocking cb @(posedge core_clk_in); endclocking
default disable iff (reset_in);
a_pin_needs_enable: assert property (
    !int_oe_n_out |-> ((enable_out[4] | enable_out[7]) && (filt_irq_out | unfilt_irq_out)))
    else $error("pin driven without flag and enable");
a_pin_when_enabled: assert property (
    ((enable_out[4] | enable_out[7]) && (filt_irq_out | unfilt_irq_out)) |-> !int_oe_n_out)
    else $error("pin idle with flag and enable");
a_filt_holds: assert property ($fell(filt_irq_out) |-> $past(wr_byte_valid_in, 2) ||
    $past(wr_byte_valid_in, 3)) else $error("filtered flag dropped without command");
a_unfilt_holds: assert property ($fell(unfilt_irq_out) |-> $past(wr_byte_valid_in, 2) ||
    $past(wr_byte_valid_in, 3)) else $error("unfiltered flag dropped without command");
a_pointer_holds: assert property ($changed(reg_pointer_out) |-> $past(wr_byte_valid_in, 2) ||
    $past(wr_byte_valid_in, 3)) else $error("pointer moved without command");
a_write_from_byte: assert property (reg_wr_out |-> $past(wr_byte_valid_in, 1) ||
    $past(wr_byte_valid_in, 2)) else $error("register write without byte");
a_force_sets: assert property (wr_start_in ##1 (wr_byte_valid_in && wr_byte_in == 8'hE4)
    |-> ##[1:3] (filt_irq_out && unfilt_irq_out)) else $error("force did not set flags");
a_clear_both: assert property (wr_start_in ##1 (wr_byte_valid_in && wr_byte_in == 8'hE7)
    |-> ##[1:3] !(filt_irq_out | unfilt_irq_out)) else $error("clear both left a flag");
a_clear_filt: assert property (wr_start_in ##1 (wr_byte_valid_in && wr_byte_in == 8'hE6)
    |-> ##[1:3] !filt_irq_out) else $error("clear left filtered flag");
endmodule // light_sensor_command_decoder_checker

// ==== host_model.sv ====
`timescale 1ns/1ps
module host_model (
    input wire clk_in,
    output reg wr_start_out = 1'b0,
    output reg wr_byte_valid_out = 1'b0,
    output reg [7:0] wr_byte_out = 8'h00
);
task xfer(input [7:0] cmd, input [7:0] data, input has_data);
    begin
        @(posedge clk_in) wr_start_out <= 1'b1;
        @(posedge clk_in) {wr_start_out, wr_byte_valid_out, wr_byte_out} <= {2'b01, cmd | 8'h80};
        @(posedge clk_in) {wr_byte_valid_out, wr_byte_out} <= {has_data, has_data ? data : ~cmd};
        // released line shows the inverse of the prior value, which is the command byte again when no data byte is sent
        @(posedge clk_in) {wr_byte_valid_out, wr_byte_out} <= {1'b0, ~wr_byte_out};
        repeat (4) @(posedge clk_in);
        #1;
    end
endtask
endmodule // host_model

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
reg core_clk_in = 0, reset_in = 1, rd_byte_taken_in = 0, filt_event_in = 0, unfilt_event_in = 0;
wire wr_start_in, wr_byte_valid_in, reg_wr_out, filt_irq_out, unfilt_irq_out, int_n_out, int_oe_n_out;
wire [7:0] wr_byte_in, reg_wr_data_out, rd_data_out, enable_out;
wire [4:0] reg_pointer_out;
integer num_errors = 0, samples_checked = 0, i;
initial forever #25 core_clk_in = ~core_clk_in;
host_model host_u (.clk_in(core_clk_in), .wr_start_out(wr_start_in), .wr_byte_valid_out(wr_byte_valid_in),
    .wr_byte_out(wr_byte_in));
light_sensor_command_decoder dut_u (.core_clk_in(core_clk_in), .reset_in(reset_in), .wr_start_in(wr_start_in),
    .wr_byte_valid_in(wr_byte_valid_in), .wr_byte_in(wr_byte_in), .rd_byte_taken_in(rd_byte_taken_in),
    .filt_event_in(filt_event_in), .unfilt_event_in(unfilt_event_in), .reg_pointer_out(reg_pointer_out),
    .reg_wr_out(reg_wr_out), .reg_wr_data_out(reg_wr_data_out), .rd_data_out(rd_data_out),
    .enable_out(enable_out), .filt_irq_out(filt_irq_out), .unfilt_irq_out(unfilt_irq_out),
    .int_n_out(int_n_out), .int_oe_n_out(int_oe_n_out));
task chk(input string what, input [7:0] exp, input [7:0] got);
    begin
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    end
endtask
task final_report;
    begin
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
endtask
////////////////////////////////////////////////////////////////////////////////
task s_enable;
    begin
        chk("oe_n", 8'h01, int_oe_n_out);
        host_u.xfer(8'hA0, 8'h90, 1);
        chk("enable", 8'h90, enable_out);
        chk("rd_data", 8'h90, rd_data_out);
        chk("wr_data", 8'h90, reg_wr_data_out);
    end
endtask
task s_force;
    begin
        host_u.xfer(8'hE4, 8'h00, 0);
        chk("flags", 8'h03, {filt_irq_out, unfilt_irq_out});
        chk("oe_n", 8'h00, int_oe_n_out);
        chk("int_n", 8'h00, int_n_out);
        host_u.xfer(8'hB3, 8'h00, 0);
        chk("pointer", 8'h13, reg_pointer_out);
        chk("status", 8'h30, rd_data_out & 8'h30);
    end
endtask
task s_clears;
    begin
        for (i = 0; i < 3; i = i + 1) begin
            host_u.xfer(8'hE4, 8'h00, 0);
            host_u.xfer(i == 0 ? 8'hE6 : i == 1 ? 8'hEA : 8'hE7, 8'h00, 0);
            chk("flags", i == 0 ? 8'h01 : i == 1 ? 8'h02 : 8'h00, {filt_irq_out, unfilt_irq_out});
        end
        @(posedge core_clk_in) {filt_event_in, unfilt_event_in} <= 2'b11;
        @(posedge core_clk_in) {filt_event_in, unfilt_event_in} <= 2'b00;
        repeat (3) @(posedge core_clk_in);
        #1 chk("events", 8'h03, {filt_irq_out, unfilt_irq_out});
        host_u.xfer(8'hE7, 8'h00, 0);
    end
endtask
task s_mask;
    begin
        host_u.xfer(8'hA0, 8'h00, 1);
        host_u.xfer(8'hE4, 8'h00, 0);
        chk("oe_n", 8'h01, int_oe_n_out);
        host_u.xfer(8'hA0, 8'h80, 1);
        chk("oe_n", 8'h00, int_oe_n_out);
        host_u.xfer(8'hE7, 8'h00, 0);
        chk("oe_n", 8'h01, int_oe_n_out);
    end
endtask
initial begin
    repeat (12) @(posedge core_clk_in);
    reset_in <= 1'b0;
    #1 s_enable;
    s_force;
    s_clears;
    s_mask;
    final_report;
end
endmodule // tb
bind light_sensor_command_decoder light_sensor_command_decoder_checker chk_u (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .wr_start_in(wr_start_in),
    .wr_byte_valid_in(wr_byte_valid_in), .wr_byte_in(wr_byte_in), .rd_byte_taken_in(rd_byte_taken_in),
    .filt_event_in(filt_event_in), .unfilt_event_in(unfilt_event_in), .reg_pointer_out(reg_pointer_out),
    .reg_wr_out(reg_wr_out), .reg_wr_data_out(reg_wr_data_out), .rd_data_out(rd_data_out),
    .enable_out(enable_out), .filt_irq_out(filt_irq_out), .unfilt_irq_out(unfilt_irq_out),
    .int_n_out(int_n_out), .int_oe_n_out(int_oe_n_out));
